// *** pkg/power_ctl_pkg.sv ***
package power_ctl_pkg;

    localparam int NUM_PERIPH = 8;
    localparam int OSC_SEL_W = 3;
    localparam logic [OSC_SEL_W-1:0] OSC_SEL_RST = 3'h0;
    localparam logic [OSC_SEL_W-1:0] OSC_SEL_ONCHIP = 3'h0;
    localparam int RESUME_CYCLES = 2;
    localparam int ENTRY_CYCLES = 1;

    typedef enum logic [1:0] {
        REG_FULL_ACTIVE,
        REG_FULL_STANDBY,
        REG_LOW_ACTIVE,
        REG_LOW_STANDBY
    } reg_mode_t;

    typedef struct packed {
        logic valid;
        logic sleepNotIdle;
    } mode_req_t;

    typedef struct packed {
        logic coreClkEn;
        logic sysClkEn;
        logic oscEn;
        logic lowRateOscEn;
        logic clkMonEn;
    } clk_gate_t;

endpackage

// *** hw/sleep_idle_power_control.sv ***
`timescale 1ns/1ps
module sleep_idle_power_control
    import power_ctl_pkg::*;
#(
    parameter int NPERIPH = NUM_PERIPH
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire mode_req_t modeReq,
    input wire logic irqPending,
    input wire logic wdtTimeout,
    input wire logic wdtEnable,
    input wire logic clkMonEnable,
    input wire logic regulatorKeepActive,
    input wire logic lowPowerRegulatorEnable,
    input wire logic clkCfgLocked,
    input wire logic newOscWrite,
    input wire logic [OSC_SEL_W-1:0] newOscSelect,
    input wire logic [NPERIPH-1:0] stopInIdle,
    input wire logic [NPERIPH-1:0] extClocked,
    output logic modeAck,
    output logic wakeEvent,
    output logic wdtClear,
    output clk_gate_t clkGate,
    output logic [NPERIPH-1:0] periphClkEn,
    output logic inSleep,
    output logic inIdle,
    output reg_mode_t regMode,
    output logic [OSC_SEL_W-1:0] activeOscSelect
);

    typedef enum logic [2:0] {
        ST_RUN,
        ST_ENTER,
        ST_SLEEP,
        ST_IDLE,
        ST_RESUME
    } state_t;

    state_t state_r;
    logic sleepSel_r;
    logic wakeHeld_r;
    logic [1:0] resumeCnt_r;
    logic [OSC_SEL_W-1:0] oscSel_r;
    logic [OSC_SEL_W-1:0] entryOsc_r;
    logic wakeSrc;
    logic [1:0] entryCnt_r;
    logic [OSC_SEL_W-1:0] activeOsc_r;
    logic lowPower;
    logic entryDone;
    logic oscAccept;

    function automatic logic is_low_power(input state_t s);
        return (s == ST_SLEEP) || (s == ST_IDLE);
    endfunction

    // Regulator choice only matters while the system clock is stopped
    function automatic reg_mode_t regulator_mode(
        input logic lowPower,
        input logic keepActive
    );
        reg_mode_t mode;
        mode = REG_LOW_STANDBY;
        case ({lowPower, keepActive})
            2'b01: begin
                mode = REG_FULL_ACTIVE;
            end
            2'b00: begin
                mode = REG_FULL_STANDBY;
            end
            2'b11: begin
                mode = REG_LOW_ACTIVE;
            end
            default: begin
                mode = REG_LOW_STANDBY;
            end
        endcase
        return mode;
    endfunction

    function automatic logic [NPERIPH-1:0] periph_gate(
        input logic sleeping,
        input logic idling,
        input logic [NPERIPH-1:0] stopMask,
        input logic [NPERIPH-1:0] extMask
    );
        logic [NPERIPH-1:0] en;
        en = '1;
        for (int i = 0; i < NPERIPH; i++) begin
            if (sleeping) begin
                en[i] = extMask[i];
            end else if (idling) begin
                en[i] = !stopMask[i];
            end else begin
                en[i] = 1'b1;
            end
        end
        return en;
    endfunction

    // The monitor is off in Sleep, so there only the watchdog keeps the slow oscillator
    function automatic logic slow_osc_needed(
        input logic sleeping,
        input logic wdtOn,
        input logic monOn
    );
        logic need;
        need = wdtOn;
        if (!sleeping) begin
            need = wdtOn || monOn;
        end
        return need;
    endfunction

    assign lowPower = is_low_power(state_r);
    assign entryDone = (state_r == ST_ENTER) && (entryCnt_r == 2'h0);
    assign oscAccept = newOscWrite && !clkCfgLocked && (state_r == ST_RUN);

    assign wakeSrc = irqPending | wdtTimeout;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= ST_RUN;
            sleepSel_r <= 1'b0;
            resumeCnt_r <= 2'h0;
            entryCnt_r <= 2'h0;
        end else begin
            case (state_r)
                ST_RUN: begin
                    if (modeReq.valid) begin
                        state_r <= ST_ENTER;
                        sleepSel_r <= modeReq.sleepNotIdle;
                        entryCnt_r <= 2'(ENTRY_CYCLES - 1);
                    end
                end
                ST_ENTER: begin
                    // Entry always completes; a wake seen here is held, not dropped
                    if (entryDone) begin
                        state_r <= sleepSel_r ? ST_SLEEP : ST_IDLE;
                    end else begin
                        entryCnt_r <= entryCnt_r - 2'h1;
                    end
                end
                ST_SLEEP, ST_IDLE: begin
                    if (wakeSrc || wakeHeld_r) begin
                        state_r <= ST_RESUME;
                        resumeCnt_r <= 2'(RESUME_CYCLES - 1);
                    end
                end
                ST_RESUME: begin
                    if (resumeCnt_r == 2'h0) begin
                        state_r <= ST_RUN;
                    end else begin
                        resumeCnt_r <= resumeCnt_r - 2'h1;
                    end
                end
                default: state_r <= ST_RUN;
            endcase
        end
    end

    // Wake arriving during entry is remembered until the low-power state is reached
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wakeHeld_r <= 1'b0;
        end else if (state_r == ST_ENTER && wakeSrc) begin
            wakeHeld_r <= 1'b1;
        end else if (lowPower) begin
            wakeHeld_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            oscSel_r <= OSC_SEL_RST;
        end else if (oscAccept) begin
            oscSel_r <= newOscSelect;
        end
    end

    // Snapshot at entry so a wake always restarts on the same source
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            entryOsc_r <= OSC_SEL_RST;
        end else if (entryDone) begin
            entryOsc_r <= oscSel_r;
        end
    end

    // Output select leaves on a flop; it follows the live select in run and
    // the entry snapshot from the end of entry until run is reached again
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            activeOsc_r <= OSC_SEL_RST;
        end else if (oscAccept) begin
            activeOsc_r <= newOscSelect;
        end else if (entryDone) begin
            activeOsc_r <= oscSel_r;
        end else if (lowPower || state_r == ST_RESUME) begin
            activeOsc_r <= entryOsc_r;
        end else begin
            activeOsc_r <= oscSel_r;
        end
    end

    assign activeOscSelect = activeOsc_r;

    assign inSleep = (state_r == ST_SLEEP);
    assign inIdle = (state_r == ST_IDLE);
    // Ack in the last entry cycle; gating is in force from the next edge on
    assign modeAck = entryDone;
    assign wakeEvent = lowPower && (wakeSrc || wakeHeld_r);
    assign wdtClear = entryDone && (sleepSel_r ? wdtEnable : 1'b1);

    always_comb begin
        clkGate.coreClkEn = !lowPower;
        clkGate.sysClkEn = !inSleep;
        clkGate.oscEn = !(inSleep && entryOsc_r == OSC_SEL_ONCHIP);
        clkGate.clkMonEn = clkMonEnable && !inSleep;
        clkGate.lowRateOscEn = slow_osc_needed(inSleep, wdtEnable, clkMonEnable);
    end

    always_comb begin
        periphClkEn = periph_gate(inSleep, inIdle, stopInIdle, extClocked);
    end

    // Regulators run at full power whenever the system clock runs
    always_comb begin
        regMode = REG_FULL_ACTIVE;
        if (inSleep) begin
            regMode = regulator_mode(lowPowerRegulatorEnable, regulatorKeepActive);
        end
    end

endmodule

// *** verif/pwr_chk_assertions.sv ***
`timescale 1ns/1ps
module pwr_chk
    import power_ctl_pkg::*;
#(
    parameter int NPERIPH = NUM_PERIPH
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wdtEnable,
    input wire logic regulatorKeepActive,
    input wire logic lowPowerRegulatorEnable,
    input wire logic [NPERIPH-1:0] stopInIdle,
    input wire logic [NPERIPH-1:0] extClocked,
    input wire logic modeAck,
    input wire logic wakeEvent,
    input wire logic wdtClear,
    input wire clk_gate_t clkGate,
    input wire logic [NPERIPH-1:0] periphClkEn,
    input wire logic inSleep,
    input wire logic inIdle,
    input wire reg_mode_t regMode
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    ack_then_mode_a: assert property (modeAck |=> inSleep || inIdle)
        else $error("no mode after ack");
    sleep_gate_a: assert property (
        inSleep |-> !clkGate.sysClkEn && !clkGate.clkMonEn)
        else $error("clock on in sleep");
    sleep_lrc_a: assert property (inSleep && wdtEnable |-> clkGate.lowRateOscEn)
        else $error("slow osc off");
    clear_on_ack_a: assert property (wdtClear |-> modeAck)
        else $error("stray clear");
    idle_gate_a: assert property (
        inIdle |-> !clkGate.coreClkEn && periphClkEn == ~stopInIdle)
        else $error("idle gating");
    sleep_periph_a: assert property (inSleep |-> periphClkEn == extClocked)
        else $error("sleep gating");
    reg_mode_a: assert property (
        inSleep |-> regMode == {lowPowerRegulatorEnable, !regulatorKeepActive})
        else $error("regulator mode");
    wake_exit_a: assert property (
        wakeEvent |=> (clkGate.coreClkEn && !inSleep && !inIdle) [*2])
        else $error("no resume");
    cover property (inIdle && wakeEvent);
    cover property (inSleep && wakeEvent);
    cover property (modeAck && !wdtClear);
    cover property (inSleep && regMode == REG_FULL_ACTIVE);
endmodule
bind sleep_idle_power_control pwr_chk #(.NPERIPH(NPERIPH)) chk_u (.sys_clk, .rst, .wdtEnable,
    .regulatorKeepActive, .lowPowerRegulatorEnable, .stopInIdle, .extClocked, .modeAck,
    .wakeEvent, .wdtClear, .clkGate, .periphClkEn, .inSleep, .inIdle, .regMode);

// *** verif/core_model.sv ***
`timescale 1ns/1ps
module core_model import power_ctl_pkg::*; (
    input wire logic req,
    input wire logic sel,
    output mode_req_t modeReq
);
    // One request per power-save instruction; the caller keeps req to a single cycle
    assign modeReq = '{valid: req, sleepNotIdle: sel};
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
    import power_ctl_pkg::*;
    logic sys_clk = 0, rst = 1, req = 0, sel = 0, irqPending = 0, wdtTimeout = 0;
    logic wdtEnable = 0, clkMonEnable = 1, regulatorKeepActive = 0;
    logic lowPowerRegulatorEnable = 1, clkCfgLocked = 0, newOscWrite = 0;
    logic modeAck, wakeEvent, wdtClear, inSleep, inIdle;
    logic [OSC_SEL_W-1:0] newOscSelect = 3'h0, activeOscSelect;
    logic [NUM_PERIPH-1:0] stopInIdle = 8'hA5, extClocked = 8'h0F, periphClkEn;
    mode_req_t modeReq;
    clk_gate_t clkGate;
    reg_mode_t regMode;
    int err_total = 0, n_tests = 0, cyc = 0;
    always #25 sys_clk = ~sys_clk;
    core_model core_u (.req, .sel, .modeReq);
    sleep_idle_power_control dut_u (.sys_clk, .rst, .modeReq, .irqPending, .wdtTimeout,
        .wdtEnable, .clkMonEnable, .regulatorKeepActive, .lowPowerRegulatorEnable,
        .clkCfgLocked, .newOscWrite, .newOscSelect, .stopInIdle, .extClocked, .modeAck,
        .wakeEvent, .wdtClear, .clkGate, .periphClkEn, .inSleep, .inIdle, .regMode,
        .activeOscSelect);
    task automatic chk(input logic ok, input string what);
        n_tests++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Wake arriving during entry must still be seen once the mode is reached
    task automatic enter(input logic s, input logic clr, input logic irq);
        sel = s;
        req = 1;
        @(negedge sys_clk);
        req = 0;
        irqPending = irq;
        chk(modeAck === 1'b1 && wdtClear === clr, "entry ack");
        @(negedge sys_clk);
        // A wake raised only during entry must survive as a held wake
        irqPending = 0;
    endtask
    task automatic leave();
        #1;
        chk(wakeEvent === 1'b1, "wake");
        @(negedge sys_clk);
        chk(clkGate.coreClkEn === 1'b1 && inIdle === 1'b0 && inSleep === 1'b0, "resume");
        irqPending = 0;
        wdtTimeout = 0;
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic osc(input logic [OSC_SEL_W-1:0] v);
        newOscSelect = v;
        newOscWrite = 1;
        @(negedge sys_clk);
        newOscWrite = 0;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 1000) begin
            err_total++;
            summarize();
        end
    end
    initial begin
        repeat (20) @(negedge sys_clk);
        rst = 0;
        enter(1'b0, 1'b1, 1'b0);
        chk(inIdle === 1'b1 && clkGate.coreClkEn === 1'b0, "idle");
        chk(clkGate.sysClkEn === 1'b1, "idle sysclk");
        chk(periphClkEn === ~stopInIdle && clkGate.lowRateOscEn === 1'b1, "idle en");
        irqPending = 1;
        leave();
        $display("idle done");
        osc(3'h5);
        wdtEnable = 1;
        enter(1'b1, 1'b1, 1'b0);
        chk(inSleep === 1'b1 && !clkGate.sysClkEn && !clkGate.clkMonEn, "sleep");
        chk(periphClkEn === extClocked && clkGate.lowRateOscEn === 1'b1, "sleep en");
        chk(regMode === REG_LOW_STANDBY && activeOscSelect === 3'h5, "sleep mode");
        osc(3'h2);
        wdtTimeout = 1;
        leave();
        chk(activeOscSelect === 3'h5, "osc kept");
        $display("sleep done");
        wdtEnable = 0;
        regulatorKeepActive = 1;
        lowPowerRegulatorEnable = 0;
        enter(1'b1, 1'b0, 1'b1);
        chk(inSleep === 1'b1 && regMode === REG_FULL_ACTIVE, "keep active");
        leave();
        $display("hold done");
        clkCfgLocked = 1;
        osc(3'h7);
        chk(activeOscSelect === 3'h5, "locked");
        clkCfgLocked = 0;
        osc(3'h3);
        chk(activeOscSelect === 3'h3, "unlocked");
        $display("osc done");
        enter(1'b0, 1'b1, 1'b0);
        rst = 1;
        repeat (2) @(negedge sys_clk);
        chk(inIdle === 1'b0 && clkGate.coreClkEn === 1'b1, "reset wake");
        chk(activeOscSelect === OSC_SEL_RST, "reset osc");
        rst = 0;
        @(negedge sys_clk);
        $display("reset done");
        summarize();
    end
endmodule
